// *** design/tpf_pkg.sv ***
// tpf_pkg: constants and types shared by the packet header framer files
// assumes byte-wide streams and a single system clock
`default_nettype none
package tpf_pkg;
   typedef enum logic [2:0] {ENC_UDP4, ENC_UDP6, ENC_MPLS, ENC_MEF, ENC_L2TP4} tpf_encap_t;
   localparam int HDR_MAX = 70;
   localparam int HDR_W = HDR_MAX * 8;
   typedef logic [HDR_W-1:0] tpf_hdr_t;
   // 56 preamble bits sent as seven bytes
   localparam int PRE_BITS = 56;
   localparam logic [10:0] PRE_LAST = 11'(PRE_BITS / 8 - 1);
   localparam logic [7:0] PRE_BYTE = 8'h55;
   // sent lsb first this byte is 10101011 on the line
   localparam logic [7:0] SFD_BYTE = 8'hD5;
   localparam logic [7:0] PAD_BYTE = 8'h00;
   localparam int MAX_DATA = 1500;
   localparam int MIN_FRAME = 64;
   localparam int FCS_LEN = 4;
   localparam logic [10:0] MIN_BODY = 11'(MIN_FRAME - FCS_LEN);
   localparam logic [10:0] FCS_LAST = 11'(FCS_LEN - 1);
   localparam logic [15:0] TPID_STD = 16'h8100;
   localparam logic [15:0] ET_IP4 = 16'h0800;
   localparam logic [15:0] ET_IP6 = 16'h86DD;
   localparam logic [15:0] ET_MPLS = 16'h8847;
   localparam logic [15:0] ET_MEF = 16'h88D8;
   localparam logic [3:0] IP4_VER = 4'h4;
   localparam logic [3:0] IP4_IHL = 4'h5;
   localparam logic [2:0] IP4_FLAGS = 3'h2;
   localparam logic [12:0] IP4_FRAG = 13'h0000;
   localparam int IP4_CSUM_LSB = 64;
   localparam logic [3:0] IP6_VER = 4'h6;
   localparam logic [7:0] PROTO_UDP = 8'h11;
   localparam logic [7:0] PROTO_L2TP = 8'h73;
   localparam logic [15:0] UDP_PORT = 16'h085E;
   localparam logic [6:0] L_ADDR = 7'h0C;
   localparam logic [6:0] L_TYPE = 7'h02;
   localparam logic [6:0] L_WORD = 7'h04;
   localparam logic [6:0] L_DWORD = 7'h08;
   localparam logic [6:0] L_IP4 = 7'h14;
   localparam logic [6:0] L_IP6A = 7'h10;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_RES = 32'hDEBB20E3;
   localparam logic [1:0] BUF_FULL = 2'h2;
endpackage
`default_nettype wire

// *** design/tpf_crc32.sv ***
// tpf_crc32: byte-serial frame check sequence register, lsb-first bit order
// assumes the caller marks the first byte of each frame
`default_nettype none
module tpf_crc32 (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic first_i,
   input wire logic [7:0] data_i,
   output logic [31:0] crc_o
);
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ tpf_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // first byte restarts from the seed so no separate clear cycle is needed
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         crc_o <= tpf_pkg::CRC_INIT;
      end else if (en_i) begin
         crc_o <= crc_step(first_i ? tpf_pkg::CRC_INIT : crc_o, data_i);
      end
   end
endmodule
`default_nettype wire

// *** design/tpf_pipe_buf.sv ***
// tpf_pipe_buf: two-entry buffer with valid and ready on both sides
// assumes one clock; the drain side may stall at any time
`default_nettype none
module tpf_pipe_buf #(
   parameter int W = 10
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic [W-1:0] mem [2];
   logic wp;
   logic rp;
   logic [1:0] fill;
   logic push;
   logic pop;

   assign in_ready_o = fill != tpf_pkg::BUF_FULL;
   assign out_valid_o = fill != 2'h0;
   assign out_data_o = mem[rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wp] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wp <= 1'b0;
         rp <= 1'b0;
         fill <= 2'h0;
      end else begin
         wp <= wp ^ push;
         rp <= rp ^ pop;
         fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule
`default_nettype wire

// *** design/tpf_framer.sv ***
// tpf_framer: builds the outgoing header stack and checks the frame crc inbound
// assumes config ports hold steady while a frame is in flight
`default_nettype none
module tpf_framer (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sw_rst_i,
   input wire tpf_pkg::tpf_encap_t cfg_encap_i,
   input wire logic [47:0] cfg_dst_mac_i,
   input wire logic [47:0] cfg_src_mac_i,
   input wire logic [1:0] cfg_vlan_cnt_i,
   input wire logic [1:0] cfg_tpid_sel_i,
   input wire logic [15:0] second_tag_protocol_id_value_i,
   input wire logic [15:0] cfg_tci0_i,
   input wire logic [15:0] cfg_tci1_i,
   input wire logic [127:0] cfg_src_ip_i,
   input wire logic [127:0] cfg_dst_ip_i,
   input wire logic [7:0] cfg_tos_i,
   input wire logic [19:0] cfg_flow_i,
   input wire logic [7:0] cfg_ttl_i,
   input wire logic [31:0] cfg_bundle_i,
   input wire logic cfg_oam_i,
   input wire logic cfg_bid_src_i,
   input wire logic [1:0] cfg_mpls_outer_i,
   input wire logic [19:0] cfg_label0_i,
   input wire logic [19:0] cfg_label1_i,
   input wire logic [2:0] cfg_exp_i,
   input wire logic [1:0] cfg_cookie_len_i,
   input wire logic [63:0] cfg_cookie_i,
   input wire logic tx_start_i,
   input wire logic [15:0] tx_len_i,
   output logic tx_busy_o,
   output logic tx_err_o,
   input wire logic [7:0] pay_data_i,
   input wire logic pay_valid_i,
   output logic pay_ready_o,
   output logic [7:0] mac_data_o,
   output logic mac_sof_o,
   output logic mac_eof_o,
   output logic mac_valid_o,
   input wire logic mac_ready_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic rx_first_i,
   input wire logic rx_last_i,
   output logic rx_ok_o,
   output logic rx_drop_o
);
   typedef enum logic [2:0] {S_IDLE, S_PRE, S_SFD, S_HDR, S_PAY, S_PAD, S_FCS} tpf_state_t;

   function automatic tpf_pkg::tpf_hdr_t push(input tpf_pkg::tpf_hdr_t v,
                                               input logic [159:0] f, input logic [6:0] n);
      return (v << {n, 3'b000}) | tpf_pkg::tpf_hdr_t'(f);
   endfunction

   function automatic logic [15:0] ip_csum(input logic [159:0] h);
      logic [31:0] s;
      s = '0;
      for (int i = 0; i < 10; i++) begin
         s = s + {16'h0000, h[i*16 +: 16]};
      end
      s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
      s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
      return ~s[15:0];
   endfunction

   tpf_state_t state;
   logic rst;
   logic [10:0] cnt;
   logic [10:0] fc;
   logic [15:0] plen;
   logic [15:0] ip_id;
   tpf_pkg::tpf_hdr_t hv;
   tpf_pkg::tpf_hdr_t hsh;
   logic [6:0] hn;
   logic [6:0] en;
   logic [6:0] ckn;
   logic [159:0] ip4;
   logic [15:0] bid16;
   logic [63:0] udp_hdr;
   logic [7:0] hbyte;
   logic [31:0] tx_crc;
   logic [31:0] fcs_word;
   logic [31:0] rx_crc;
   logic emit_v;
   logic emit_l;
   logic [7:0] emit_d;
   logic buf_ready;
   logic fire;
   logic bad_len;
   logic bad_sid;
   logic start_ok;
   logic body_short;
   logic rx_end;
   logic [9:0] buf_out;

   assign rst = rst_i || sw_rst_i;

   function automatic logic [159:0] tag(input logic sel, input logic [15:0] tpid2,
                                        input logic [15:0] tci);
      return 160'({sel ? tpid2 : tpf_pkg::TPID_STD, tci});
   endfunction

   // header is assembled right-aligned and then shifted out a byte at a time
   always_comb begin
      hv = '0;
      hn = '0;
      ip4 = '0;
      ckn = cfg_cookie_len_i == 2'h0 ? 7'h00 :
            (cfg_cookie_len_i == 2'h1 ? tpf_pkg::L_WORD : tpf_pkg::L_DWORD);
      bid16 = cfg_oam_i ? 16'hFFFF : cfg_bundle_i[15:0];
      udp_hdr = {cfg_bid_src_i ? bid16 : tpf_pkg::UDP_PORT,
                 cfg_bid_src_i ? tpf_pkg::UDP_PORT : bid16,
                 16'(tpf_pkg::L_DWORD) + plen, 16'h0000};
      hv = push(hv, 160'({cfg_dst_mac_i, cfg_src_mac_i}), tpf_pkg::L_ADDR);
      hn = tpf_pkg::L_ADDR;
      if (cfg_vlan_cnt_i != 2'h0) begin
         hv = push(hv, tag(cfg_tpid_sel_i[0], second_tag_protocol_id_value_i, cfg_tci0_i),
                   tpf_pkg::L_WORD);
         hn = hn + tpf_pkg::L_WORD;
      end
      if (cfg_vlan_cnt_i[1]) begin
         hv = push(hv, tag(cfg_tpid_sel_i[1], second_tag_protocol_id_value_i, cfg_tci1_i),
                   tpf_pkg::L_WORD);
         hn = hn + tpf_pkg::L_WORD;
      end
      en = hn + tpf_pkg::L_TYPE;
      unique case (cfg_encap_i)
         tpf_pkg::ENC_UDP4, tpf_pkg::ENC_L2TP4: begin
            hv = push(hv, 160'(tpf_pkg::ET_IP4), tpf_pkg::L_TYPE);
            ip4 = {tpf_pkg::IP4_VER, tpf_pkg::IP4_IHL, cfg_tos_i,
                   16'(tpf_pkg::L_IP4 + plen) + ((cfg_encap_i == tpf_pkg::ENC_UDP4) ?
                   16'(tpf_pkg::L_DWORD) : 16'(tpf_pkg::L_WORD + ckn)),
                   ip_id, tpf_pkg::IP4_FLAGS, tpf_pkg::IP4_FRAG, cfg_ttl_i,
                   (cfg_encap_i == tpf_pkg::ENC_UDP4) ? tpf_pkg::PROTO_UDP
                                                     : tpf_pkg::PROTO_L2TP,
                   16'h0000, cfg_src_ip_i[31:0], cfg_dst_ip_i[31:0]};
            ip4[tpf_pkg::IP4_CSUM_LSB +: 16] = ip_csum(ip4);
            hv = push(hv, ip4, tpf_pkg::L_IP4);
            hn = en + tpf_pkg::L_IP4;
            if (cfg_encap_i == tpf_pkg::ENC_UDP4) begin
               hv = push(hv, 160'(udp_hdr), tpf_pkg::L_DWORD);
               hn = hn + tpf_pkg::L_DWORD;
            end else begin
               hv = push(hv, 160'(cfg_bundle_i), tpf_pkg::L_WORD);
               // a zero-length push would still or the cookie into the session id
               if (ckn != 7'h00) begin
                  hv = push(hv, 160'((cfg_cookie_len_i == 2'h1) ? {32'h0, cfg_cookie_i[31:0]}
                                                                 : cfg_cookie_i), ckn);
               end
               hn = hn + tpf_pkg::L_WORD + ckn;
            end
         end
         tpf_pkg::ENC_UDP6: begin
            hv = push(hv, 160'(tpf_pkg::ET_IP6), tpf_pkg::L_TYPE);
            hv = push(hv, 160'({tpf_pkg::IP6_VER, cfg_tos_i, cfg_flow_i,
                           16'(tpf_pkg::L_DWORD) + plen, tpf_pkg::PROTO_UDP, cfg_ttl_i}),
                      tpf_pkg::L_DWORD);
            hv = push(hv, 160'(cfg_src_ip_i), tpf_pkg::L_IP6A);
            hv = push(hv, 160'(cfg_dst_ip_i), tpf_pkg::L_IP6A);
            hv = push(hv, 160'(udp_hdr), tpf_pkg::L_DWORD);
            hn = en + tpf_pkg::L_DWORD + tpf_pkg::L_IP6A + tpf_pkg::L_IP6A + tpf_pkg::L_DWORD;
         end
         tpf_pkg::ENC_MPLS: begin
            hv = push(hv, 160'(tpf_pkg::ET_MPLS), tpf_pkg::L_TYPE);
            hn = en + tpf_pkg::L_WORD;
            if (cfg_mpls_outer_i != 2'h0) begin
               hv = push(hv, 160'({cfg_label0_i, cfg_exp_i, 1'b0, cfg_ttl_i}),
                         tpf_pkg::L_WORD);
               hn = hn + tpf_pkg::L_WORD;
            end
            if (cfg_mpls_outer_i[1]) begin
               hv = push(hv, 160'({cfg_label1_i, cfg_exp_i, 1'b0, cfg_ttl_i}),
                         tpf_pkg::L_WORD);
               hn = hn + tpf_pkg::L_WORD;
            end
            hv = push(hv, 160'({cfg_bundle_i[19:0], cfg_exp_i, 1'b1, cfg_ttl_i}),
                      tpf_pkg::L_WORD);
         end
         tpf_pkg::ENC_MEF: begin
            hv = push(hv, 160'(tpf_pkg::ET_MEF), tpf_pkg::L_TYPE);
            hv = push(hv, 160'({cfg_bundle_i[19:0], 12'h000}), tpf_pkg::L_WORD);
            hn = en + tpf_pkg::L_WORD;
         end
         default: begin
            hn = en;
         end
      endcase
      hsh = hv << {7'(tpf_pkg::HDR_MAX) - hn + cnt[6:0], 3'b000};
      hbyte = hsh[tpf_pkg::HDR_W-1 -: 8];
   end

   // oversize payloads and the reserved session id are refused at the start
   assign bad_len = ({10'h000, hn - en} + {1'b0, tx_len_i}) > 17'(tpf_pkg::MAX_DATA);
   assign bad_sid = cfg_encap_i == tpf_pkg::ENC_L2TP4 && cfg_bundle_i == '0;
   assign start_ok = tx_start_i && state == S_IDLE && !bad_len && !bad_sid;
   assign body_short = (fc + 11'h001) < tpf_pkg::MIN_BODY;
   assign fcs_word = ~tx_crc;
   assign fire = emit_v && buf_ready;
   assign tx_busy_o = state != S_IDLE;
   assign pay_ready_o = state == S_PAY && buf_ready;

   always_comb begin
      emit_v = 1'b1;
      emit_l = 1'b0;
      emit_d = tpf_pkg::PAD_BYTE;
      unique case (state)
         S_IDLE: emit_v = 1'b0;
         S_PRE: emit_d = tpf_pkg::PRE_BYTE;
         S_SFD: emit_d = tpf_pkg::SFD_BYTE;
         S_HDR: emit_d = hbyte;
         S_PAY: begin
            emit_v = pay_valid_i;
            emit_d = pay_data_i;
         end
         S_PAD: emit_d = tpf_pkg::PAD_BYTE;
         S_FCS: begin
            emit_d = fcs_word[{cnt[1:0], 3'b000} +: 8];
            emit_l = cnt == tpf_pkg::FCS_LAST;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst) begin
         state <= S_IDLE;
         cnt <= '0;
      end else begin
         unique case (state)
            S_IDLE: if (start_ok) begin
               state <= S_PRE;
               cnt <= '0;
            end
            S_PRE: if (fire) begin
               cnt <= cnt == tpf_pkg::PRE_LAST ? '0 : cnt + 11'h001;
               if (cnt == tpf_pkg::PRE_LAST) state <= S_SFD;
            end
            S_SFD: if (fire) state <= S_HDR;
            S_HDR: if (fire) begin
               cnt <= cnt == {4'h0, hn - 7'h01} ? '0 : cnt + 11'h001;
               if (cnt == {4'h0, hn - 7'h01}) begin
                  state <= plen != '0 ? S_PAY : (body_short ? S_PAD : S_FCS);
               end
            end
            S_PAY: if (fire) begin
               cnt <= cnt == 11'(plen - 16'h0001) ? '0 : cnt + 11'h001;
               if (cnt == 11'(plen - 16'h0001)) state <= body_short ? S_PAD : S_FCS;
            end
            S_PAD: if (fire && !body_short) state <= S_FCS;
            S_FCS: if (fire) begin
               cnt <= cnt + 11'h001;
               if (emit_l) state <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst) begin
         fc <= '0;
         plen <= '0;
         ip_id <= '0;
         tx_err_o <= 1'b0;
      end else begin
         tx_err_o <= tx_start_i && state == S_IDLE && (bad_len || bad_sid);
         if (start_ok) begin
            fc <= '0;
            plen <= tx_len_i;
         end else if (fire && (state == S_HDR || state == S_PAY || state == S_PAD)) begin
            fc <= fc + 11'h001;
         end
         if (start_ok) ip_id <= ip_id + 16'h0001;
      end
   end

   tpf_crc32 u_tx_crc (
      .mclk_i(mclk_i),
      .rst_i(rst),
      .en_i(fire && (state == S_HDR || state == S_PAY || state == S_PAD)),
      .first_i(state == S_HDR && cnt == '0),
      .data_i(emit_d),
      .crc_o(tx_crc)
   );

   // a stalled mac only holds back the byte source, never drops a byte
   tpf_pipe_buf #(.W(10)) u_out_buf (
      .mclk_i(mclk_i),
      .rst_i(rst),
      .in_valid_i(emit_v),
      .in_ready_o(buf_ready),
      .in_data_i({emit_l, state == S_PRE && cnt == '0, emit_d}),
      .out_valid_o(mac_valid_o),
      .out_ready_i(mac_ready_i),
      .out_data_o(buf_out)
   );
   assign mac_data_o = buf_out[7:0];
   assign mac_sof_o = buf_out[8];
   assign mac_eof_o = buf_out[9];

   tpf_crc32 u_rx_crc (
      .mclk_i(mclk_i),
      .rst_i(rst),
      .en_i(rx_valid_i),
      .first_i(rx_first_i),
      .data_i(rx_data_i),
      .crc_o(rx_crc)
   );

   // residue check covers the received check bytes as well
   always_ff @(posedge mclk_i) begin
      if (rst) begin
         rx_end <= 1'b0;
         rx_ok_o <= 1'b0;
         rx_drop_o <= 1'b0;
      end else begin
         rx_end <= rx_valid_i && rx_last_i;
         rx_ok_o <= rx_end && rx_crc == tpf_pkg::CRC_RES;
         rx_drop_o <= rx_end && rx_crc != tpf_pkg::CRC_RES;
      end
   end

   sequence pre_done_s;
      state == S_PRE && fire && cnt == tpf_pkg::PRE_LAST;
   endsequence
   sequence ip_first_s;
      state == S_HDR && fire && cnt == {4'h0, en} &&
      (cfg_encap_i == tpf_pkg::ENC_UDP4 || cfg_encap_i == tpf_pkg::ENC_L2TP4);
   endsequence
   // flags byte follows the first word and the identification
   sequence ip_flag_s;
      state == S_HDR && fire && cnt == {4'h0, en + tpf_pkg::L_WORD + tpf_pkg::L_TYPE} &&
      (cfg_encap_i == tpf_pkg::ENC_UDP4 || cfg_encap_i == tpf_pkg::ENC_L2TP4);
   endsequence

   pre_bytes_a: assert property (@(posedge mclk_i) disable iff (rst)
      state == S_PRE && fire |-> emit_d == tpf_pkg::PRE_BYTE) else $error("bad preamble byte");
   sfd_after_a: assert property (@(posedge mclk_i) disable iff (rst)
      pre_done_s |=> state == S_SFD && emit_d == tpf_pkg::SFD_BYTE) else $error("no delimiter");
   min_body_a: assert property (@(posedge mclk_i) disable iff (rst)
      state == S_FCS && cnt == '0 |-> fc >= tpf_pkg::MIN_BODY) else $error("frame too short");
   rx_drop_a: assert property (@(posedge mclk_i) disable iff (rst)
      rx_valid_i && rx_last_i ##1 rx_crc != tpf_pkg::CRC_RES |=> rx_drop_o && !rx_ok_o)
      else $error("bad crc kept");
   ip_ver_a: assert property (@(posedge mclk_i) disable iff (rst)
      ip_first_s |-> emit_d == {tpf_pkg::IP4_VER, tpf_pkg::IP4_IHL}) else $error("ip version");
   ip_flags_a: assert property (@(posedge mclk_i) disable iff (rst)
      ip_flag_s |-> emit_d[7:5] == tpf_pkg::IP4_FLAGS)
      else $error("ip flags");
   sid_refuse_a: assert property (@(posedge mclk_i) disable iff (rst)
      state == S_IDLE && tx_start_i && bad_sid |=> state == S_IDLE && tx_err_o)
      else $error("zero session sent");
   path_reset_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      sw_rst_i |=> state == S_IDLE && !mac_valid_o && !rx_drop_o) else $error("no reset");
   fcs_len_a: assert property (@(posedge mclk_i) disable iff (rst)
      state == S_FCS && fire && cnt == '0 |-> ##[1:40] (fire && emit_l) ##1 state == S_IDLE)
      else $error("fcs length");
endmodule
`default_nettype wire

// *** test/tpf_mac_sink.sv ***
// tpf_mac_sink: mac side model that takes framer bytes, with an optional stall
// assumes the bench pulses clr_i before each frame
`default_nettype none
module tpf_mac_sink (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   input wire logic stall_i,
   input wire logic [7:0] data_i,
   input wire logic sof_i,
   input wire logic eof_i,
   input wire logic valid_i,
   output logic ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic done;
   logic sof_ok;
   logic [1:0] ph;
   // ready two cycles in three low, so the buffer must hold words back
   assign ready_o = !stall_i || ph == 2'h0;
   always @(posedge mclk_i) begin
      ph <= (rst_i || ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (rst_i || clr_i) begin
         q.delete();
         done <= 1'b0;
      end else if (valid_i && ready_o) begin
         if (q.size() == 0) sof_ok <= sof_i;
         q.push_back(data_i);
         done <= eof_i;
      end
   end
endmodule
`default_nettype wire

// *** test/tpf_framer_bench.sv ***
// tpf_framer_bench: frames of each kind sent and checked, the udp4 frames fed back to the rx path
// assumes config changes only while no frame is in flight
`default_nettype none
module tpf_framer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, start = 1'b0, clr = 1'b0, stall = 1'b0;
   tpf_pkg::tpf_encap_t encap = tpf_pkg::ENC_UDP4;
   logic [1:0] vcnt = 2'h0, tsel = 2'h0, mout = 2'h0, ckl = 2'h0;
   logic [47:0] dmac = 48'h0A0B0C0D0E0F, smac = 48'h020304050607;
   logic [15:0] tpid2 = 16'h9100, tci0 = 16'hA123, tci1 = 16'h5456, len = 16'h0000;
   logic [127:0] sip = 128'hC0A80001, dip = 128'hC0A80002;
   logic [7:0] tos = 8'h10, ttl = 8'h40, pdata = 8'h00, rxd = 8'h00, p0;
   logic [19:0] flow = 20'h12345, lab0 = 20'hABCDE, lab1 = 20'h13579;
   logic [31:0] bundle = 32'h00012345, c;
   logic [63:0] cookie = 64'h1122334455667788;
   logic [2:0] exp = 3'h5;
   logic oam = 1'b0, bsrc = 1'b1, pvalid = 1'b1, rxv = 1'b0, rxf = 1'b0, rxl = 1'b0;
   logic busy, err, pready, mv, msof, meof, mready, rok, rdrop;
   logic [7:0] md;
   logic [7:0] f[$];
   int fail_count = 0, num_checks = 0;
   tpf_framer i_tpf_framer (.mclk_i(clk), .rst_i(rst), .sw_rst_i(sw_rst), .cfg_encap_i(encap),
      .cfg_dst_mac_i(dmac), .cfg_src_mac_i(smac), .cfg_vlan_cnt_i(vcnt), .cfg_tpid_sel_i(tsel),
      .second_tag_protocol_id_value_i(tpid2), .cfg_tci0_i(tci0), .cfg_tci1_i(tci1),
      .cfg_src_ip_i(sip), .cfg_dst_ip_i(dip), .cfg_tos_i(tos), .cfg_flow_i(flow),
      .cfg_ttl_i(ttl), .cfg_bundle_i(bundle), .cfg_oam_i(oam), .cfg_bid_src_i(bsrc),
      .cfg_mpls_outer_i(mout), .cfg_label0_i(lab0), .cfg_label1_i(lab1), .cfg_exp_i(exp),
      .cfg_cookie_len_i(ckl), .cfg_cookie_i(cookie), .tx_start_i(start), .tx_len_i(len),
      .tx_busy_o(busy), .tx_err_o(err), .pay_data_i(pdata), .pay_valid_i(pvalid),
      .pay_ready_o(pready), .mac_data_o(md), .mac_sof_o(msof), .mac_eof_o(meof),
      .mac_valid_o(mv), .mac_ready_i(mready), .rx_data_i(rxd), .rx_valid_i(rxv),
      .rx_first_i(rxf), .rx_last_i(rxl), .rx_ok_o(rok), .rx_drop_o(rdrop));
   tpf_mac_sink i_tpf_mac_sink (.mclk_i(clk), .rst_i(rst), .clr_i(clr), .stall_i(stall),
      .data_i(md), .sof_i(msof), .eof_i(meof), .valid_i(mv), .ready_o(mready));
   initial forever #4 clk = ~clk;
   // payload is a running count, so the expected byte follows from its first value
   always @(posedge clk) if (pvalid && pready) pdata <= pdata + 8'h01;
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: byte %h, expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: flag %b, expected %b", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d, errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic pulse_start(input logic [15:0] n);
      @(posedge clk) clr <= 1'b1;
      len <= n;
      @(posedge clk) clr <= 1'b0;
      p0 = pdata;
      start <= 1'b1;
      @(posedge clk) start <= 1'b0;
   endtask
   task automatic send(input logic [15:0] n);
      int i;
      pulse_start(n);
      for (i = 0; i < 4000 && i_tpf_mac_sink.done !== 1'b1; i++) @(posedge clk);
      if (i == 4000) begin
         fail_count++;
         $display("Error at %0t: frame never completed", $time);
         end_of_test();
      end
      f = i_tpf_mac_sink.q;
   endtask
   task automatic frame_chk(input int body);
      c = tpf_pkg::CRC_INIT;
      chk8(8'(f.size()), 8'(body + 12));
      for (int i = 0; i < 7; i++) chk8(f[i], 8'h55);
      chk8(f[7], 8'hD5);
      chk1(i_tpf_mac_sink.sof_ok, 1'b1);
      for (int i = 8; i < body + 8; i++) begin
         c = c ^ {24'h000000, f[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ tpf_pkg::CRC_POLY : c >> 1;
      end
      for (int k = 0; k < 4; k++) chk8(f[body + 8 + k], ~c[8*k +: 8]);
   endtask
   task automatic rx_chk(input logic bad);
      for (int i = 8; i < f.size(); i++) begin
         @(posedge clk) rxv <= 1'b1;
         rxf <= (i == 8);
         rxl <= (i == f.size() - 1);
         rxd <= f[i] ^ ((bad && i == 20) ? 8'h01 : 8'h00);
      end
      @(posedge clk) rxv <= 1'b0;
      rxl <= 1'b0;
      for (int k = 0; k < 6 && !(rok === 1'b1 || rdrop === 1'b1); k++) @(posedge clk) #1;
      chk1(rok, !bad);
      chk1(rdrop, bad);
   endtask
   task automatic refuse(input logic [15:0] n);
      pulse_start(n);
      #1;
      for (int k = 0; k < 4 && err !== 1'b1; k++) @(posedge clk) #1;
      chk1(err, 1'b1);
      chk1(busy, 1'b0);
   endtask
   task automatic t_udp4;
      logic [15:0] sp, dp;
      for (int o = 0; o < 2; o++) begin
         @(posedge clk) oam <= o[0];
         bsrc <= !o[0];
         sp = o[0] ? tpf_pkg::UDP_PORT : bundle[15:0];
         dp = o[0] ? 16'hFFFF : tpf_pkg::UDP_PORT;
         send(16'h000A);
         frame_chk(60);
         chk8(f[20], 8'h08);
         chk8(f[22], 8'h45);
         chk8(f[28] & 8'hE0, 8'h40);
         chk8(f[31], 8'h11);
         chk8(f[42], sp[15:8]);
         chk8(f[43], sp[7:0]);
         chk8(f[44], dp[15:8]);
         chk8(f[45], dp[7:0]);
         chk8(f[48] | f[49], 8'h00);
         chk8(f[59], p0 + 8'h09);
         chk8(f[63], tpf_pkg::PAD_BYTE);
         rx_chk(1'b0);
         rx_chk(1'b1);
      end
   endtask
   task automatic t_mpls;
      @(posedge clk) encap <= tpf_pkg::ENC_MPLS;
      vcnt <= 2'h1;
      tsel <= 2'h1;
      mout <= 2'h2;
      stall <= 1'b1;
      send(16'h0028);
      frame_chk(70);
      chk8(f[20], tpid2[15:8]);
      chk8(f[22], tci0[15:8]);
      chk8(f[23], tci0[7:0]);
      chk8(f[24], 8'h88);
      chk8(f[26], lab0[19:12]);
      chk1(f[28][0], 1'b0);
      chk1(f[32][0], 1'b0);
      chk8(f[34], bundle[19:12]);
      chk8(f[36], {bundle[3:0], exp, 1'b1});
   endtask
   task automatic t_l2tp;
      @(posedge clk) encap <= tpf_pkg::ENC_L2TP4;
      vcnt <= 2'h2;
      tsel <= 2'h2;
      ckl <= 2'h2;
      send(16'h0014);
      frame_chk(74);
      chk8(f[20], 8'h81);
      chk8(f[24], tpid2[15:8]);
      chk8(f[27], tci1[7:0]);
      chk8(f[39], 8'h73);
      chk8(f[50], bundle[31:24]);
      chk8(f[53], bundle[7:0]);
      chk8(f[54], cookie[63:56]);
      chk8(f[61], cookie[7:0]);
      @(posedge clk) bundle <= 32'h00000000;
      refuse(16'h0014);
      @(posedge clk) bundle <= 32'h00012345;
      encap <= tpf_pkg::ENC_UDP4;
      vcnt <= 2'h0;
      refuse(16'h05DC);
   endtask
   task automatic t_more;
      @(posedge clk) encap <= tpf_pkg::ENC_UDP6;
      send(16'h0004);
      frame_chk(66);
      chk8(f[20], 8'h86);
      chk8(f[22], {4'h6, tos[7:4]});
      chk8(f[28], 8'h11);
      chk8(f[45], sip[7:0]);
      chk8(f[62], 8'h08);
      chk8(f[64], 8'hFF);
      @(posedge clk) encap <= tpf_pkg::ENC_MEF;
      send(16'h0004);
      frame_chk(60);
      chk8(f[22], bundle[19:12]);
      chk8(f[24], {bundle[3:0], 4'h0});
      @(posedge clk) encap <= tpf_pkg::ENC_L2TP4;
      ckl <= 2'h0;
      send(16'h0004);
      frame_chk(60);
      chk8(f[45], bundle[7:0]);
      chk8(f[46], p0);
   endtask
   task automatic t_swrst;
      pulse_start(16'h0040);
      repeat (20) @(posedge clk);
      sw_rst <= 1'b1;
      @(posedge clk) sw_rst <= 1'b0;
      #1;
      chk1(busy, 1'b0);
      chk1(mv, 1'b0);
      send(16'h000A);
      frame_chk(60);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_udp4();
      t_mpls();
      t_l2tp();
      t_more();
      t_swrst();
      end_of_test();
   end
endmodule
`default_nettype wire
